// ### design/cbs_ctrl.sv
// Bank select and reset controller for the low 8 kB of code space.
// Assumes the core side drives the interface on i_ref_clk; pins are synchronous.
`timescale 1ns/1ps
module cbs_ctrl
  import cbs_pkg::*;
#(
  parameter int unsigned SIZE_KB = 64
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Reset sources
  input wire logic i_por,
  input wire logic i_rst_pin,
  input wire logic i_below_vbo,
  input wire logic i_wdog_trip,
  // Core side
  cbs_if.dev bus,
  // Status
  output logic [9:0] o_sector_count,
  output logic o_brownout
);
  logic [1:0] fcf;
  logic power_on_flag;
  logic brownout_irq_enable;
  logic [7:0] watchdog_control_reg;
  logic [2:0] bo_cnt;
  logic bo_act;
  logic bo_irq;
  logic core_rst;
  cbs_rst_src_t rst_src;
  logic [15:0] fetch_addr_q;
  logic fetch_boot;
  logic fetch_valid;
  logic [4:0] hold_cnt;

  wire hard_rst = i_por | i_rst_pin;
  wire swr_rise = bus.cfg_we & ~fcf[CBS_SWR_POS] & bus.cfg_wdata[CBS_SWR_POS];
  wire bo_reset = bo_act & (~brownout_irq_enable | (bus.ebo_we & ~bus.ebo_wdata));

  // ----------------------------------------------------------------
  // Next flash configuration, shared by the bits and the fetch map
  // ----------------------------------------------------------------
  // Same value feeds both, so a fetch never sees a stale bank
  wire [1:0] bo_wd_bits = {fcf[CBS_SWR_POS], 1'b0};
  wire [1:0] next_fcf = hard_rst ? CBS_FCF_HARD :
                        swr_rise ? CBS_FCF_SOFT :
                        (bo_reset | i_wdog_trip) ? bo_wd_bits :
                        bus.cfg_we ? bus.cfg_wdata : fcf;
  wire next_boot = (next_fcf == 2'h0) & (bus.fetch_addr <= CBS_BOOT_TOP);

  // ----------------------------------------------------------------
  // Flash configuration bits
  // ----------------------------------------------------------------
  // No RAM here: resets never touch on-chip data memory
  // Data space of 1024 B internal, 64 kB external, handled outside
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fcf <= CBS_FCF_HARD;
    end else begin
      fcf <= next_fcf;
    end
  end

  // ----------------------------------------------------------------
  // Power-on flag, set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      power_on_flag <= 1'b1;
    end else if (i_por) begin
      power_on_flag <= 1'b1;
    end else if (bus.pof_clr) begin
      power_on_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Brownout filter and enable
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bo_cnt <= 3'h0;
      bo_act <= 1'b0;
    end else if (!i_below_vbo) begin
      bo_cnt <= 3'h0;
      bo_act <= 1'b0;
    end else if (bo_cnt < 3'(CBS_BO_FILT_CYC - 1)) begin
      bo_cnt <= bo_cnt + 3'h1;
    end else begin
      bo_act <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      brownout_irq_enable <= 1'b0;
    end else if (hard_rst | swr_rise | bo_reset | i_wdog_trip) begin
      brownout_irq_enable <= 1'b0;
    end else if (bus.ebo_we) begin
      brownout_irq_enable <= bus.ebo_wdata;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bo_irq <= 1'b0;
    end else begin
      bo_irq <= bo_act & brownout_irq_enable & ~bo_reset;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog control, bit 2 survives soft reset
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      watchdog_control_reg <= CBS_WATCHDOG_CONTROL_REG_RST;
    end else if (hard_rst) begin
      watchdog_control_reg <= CBS_WATCHDOG_CONTROL_REG_RST;
    end else if (swr_rise) begin
      watchdog_control_reg <= CBS_WATCHDOG_CONTROL_REG_RST;
      watchdog_control_reg[CBS_WATCHDOG_CONTROL_REG_KEEP_POS] <= watchdog_control_reg[CBS_WATCHDOG_CONTROL_REG_KEEP_POS];
    end else if (bus.watchdog_control_reg_we) begin
      watchdog_control_reg <= bus.watchdog_control_reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Core reset, source and restart vector
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      core_rst <= 1'b1;
      rst_src <= CBS_RST_EXT;
      hold_cnt <= 5'h0;
    end else if (hard_rst) begin
      core_rst <= 1'b1;
      rst_src <= CBS_RST_EXT;
      hold_cnt <= 5'h0;
    end else if (swr_rise | bo_reset | i_wdog_trip) begin
      core_rst <= 1'b1;
      hold_cnt <= 5'h0;
      rst_src <= swr_rise ? CBS_RST_SOFT : (bo_reset ? CBS_RST_BROWN : CBS_RST_WDOG);
    end else if (core_rst && hold_cnt < 5'(CBS_POR_HOLD_CYC - 1)) begin
      hold_cnt <= hold_cnt + 5'h1;
    end else begin
      core_rst <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Fetch mapping, registered with no prefetch buffer
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fetch_addr_q <= 16'h0000;
      fetch_boot <= 1'b1;
      fetch_valid <= 1'b0;
    end else begin
      fetch_addr_q <= bus.fetch_addr;
      fetch_boot <= next_boot;
      fetch_valid <= bus.fetch_req & ~core_rst;
    end
  end

  assign bus.cfg_rdata = fcf;
  assign bus.power_on_flag = power_on_flag;
  assign bus.brownout_irq_enable = brownout_irq_enable;
  assign bus.watchdog_control_reg = watchdog_control_reg;
  assign bus.fetch_boot = fetch_boot;
  assign bus.fetch_addr_q = fetch_addr_q;
  assign bus.fetch_valid = fetch_valid;
  assign bus.core_rst = core_rst;
  assign bus.rst_src = rst_src;
  assign bus.bo_irq = bo_irq;
  assign bus.pc_load = bo_irq ? CBS_BO_VEC : CBS_RESET_VEC;
  assign bus.pc_load_en = core_rst | bo_irq;
  assign o_sector_count = 10'((SIZE_KB * 1024) / CBS_SECTOR_BYTES);
  assign o_brownout = bo_act;
endmodule

// ### design/cbs_pkg.sv
// Package for the code bank select and reset control block.
// Assumes a single 20 MHz reference clock shared by both ends.
package cbs_pkg;
  localparam int unsigned CBS_CLK_HZ = 20_000_000;
  localparam int unsigned CBS_ADDR_W = 16;
  localparam logic [15:0] CBS_BOOT_TOP = 16'h1fff;
  localparam logic [15:0] CBS_RESET_VEC = 16'h0000;
  localparam logic [15:0] CBS_BO_VEC = 16'h004b;
  localparam int unsigned CBS_SECTOR_BYTES = 128;
  localparam int unsigned CBS_RAM_BYTES = 1024;
  localparam int unsigned CBS_XDATA_BYTES = 65536;
  localparam int unsigned CBS_BO_FILT_CYC = 4;
  localparam int unsigned CBS_POR_MC = 2;
  localparam int unsigned CBS_CLK_PER_MC = 12;
  localparam int unsigned CBS_POR_HOLD_CYC = CBS_POR_MC * CBS_CLK_PER_MC;
  localparam int unsigned CBS_AUTOBAUD_MS = 400;
  localparam int unsigned CBS_AUTOBAUD_CYC = (CBS_CLK_HZ / 1000) * CBS_AUTOBAUD_MS;
  localparam int unsigned CBS_SWR_POS = 1;
  localparam int unsigned CBS_BANK_SELECT_BIT_POS = 0;
  localparam logic [1:0] CBS_FCF_HARD = 2'h0;
  localparam logic [1:0] CBS_FCF_SOFT = 2'h2;
  localparam int unsigned CBS_WATCHDOG_CONTROL_REG_KEEP_POS = 2;
  localparam logic [7:0] CBS_WATCHDOG_CONTROL_REG_RST = 8'h00;
  typedef enum logic [2:0] {
    CBS_RST_NONE = 3'b000,
    CBS_RST_EXT = 3'b001,
    CBS_RST_SOFT = 3'b010,
    CBS_RST_BROWN = 3'b011,
    CBS_RST_WDOG = 3'b100
  } cbs_rst_src_t;
endpackage

// ### design/cbs_if.sv
// Interface joining the bank/reset controller and the core/boot side.
// Assumes both ends share i_ref_clk.
`timescale 1ns/1ps
interface cbs_if;
  logic [1:0] cfg_wdata;
  logic cfg_we;
  logic [1:0] cfg_rdata;
  logic pof_clr;
  logic power_on_flag;
  logic ebo_wdata;
  logic ebo_we;
  logic brownout_irq_enable;
  logic [7:0] watchdog_control_reg_wdata;
  logic watchdog_control_reg_we;
  logic [7:0] watchdog_control_reg;
  logic [15:0] fetch_addr;
  logic fetch_req;
  logic fetch_boot;
  logic [15:0] fetch_addr_q;
  logic fetch_valid;
  logic core_rst;
  logic [2:0] rst_src;
  logic [15:0] pc_load;
  logic pc_load_en;
  logic bo_irq;
  modport dev (
    input cfg_wdata, cfg_we, pof_clr, ebo_wdata, ebo_we, watchdog_control_reg_wdata, watchdog_control_reg_we, fetch_addr, fetch_req,
    output cfg_rdata, power_on_flag, brownout_irq_enable, watchdog_control_reg, fetch_boot, fetch_addr_q, fetch_valid, core_rst, rst_src,
    output pc_load, pc_load_en, bo_irq
  );
  modport core (
    output cfg_wdata, cfg_we, pof_clr, ebo_wdata, ebo_we, watchdog_control_reg_wdata, watchdog_control_reg_we, fetch_addr, fetch_req,
    input cfg_rdata, power_on_flag, brownout_irq_enable, watchdog_control_reg, fetch_boot, fetch_addr_q, fetch_valid, core_rst, rst_src,
    input pc_load, pc_load_en, bo_irq
  );
endinterface

// ### design/cbs_core.sv
// Core-side end: boot firmware sequencer and fetch requester.
// Assumes the controller resets it via core_rst; RAM lives elsewhere and is untouched.
`timescale 1ns/1ps
module cbs_core
  import cbs_pkg::*;
#(
  parameter int unsigned AUTOBAUD_CYC = CBS_AUTOBAUD_CYC
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // User side
  input wire logic i_autobaud_ok,
  input wire logic i_ice_flag,
  input wire logic i_cfg_we,
  input wire logic [1:0] i_cfg_wdata,
  input wire logic i_ebo_we,
  input wire logic i_ebo_wdata,
  input wire logic i_pof_clr,
  input wire logic i_fetch_req,
  input wire logic [15:0] i_fetch_addr,
  output logic o_in_boot,
  output logic o_isp_mode,
  output logic o_ice_mode,
  // Controller side
  cbs_if.core bus
);
  typedef enum logic [1:0] {
    CBS_C_WAIT = 2'b00,
    CBS_C_BAUD = 2'b01,
    CBS_C_ISP = 2'b10,
    CBS_C_USER = 2'b11
  } cbs_core_st_t;
  cbs_core_st_t st;
  logic [23:0] baud_cnt;
  logic [15:0] pc;
  logic timeout_sw;

  wire boot_start = bus.core_rst && bus.rst_src == CBS_RST_EXT;
  wire timeout = st == CBS_C_BAUD && baud_cnt >= 24'(AUTOBAUD_CYC - 1);

  // ----------------------------------------------------------------
  // Boot sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st <= CBS_C_WAIT;
      baud_cnt <= 24'h0;
      o_ice_mode <= 1'b0;
    end else if (boot_start) begin
      st <= CBS_C_BAUD;
      baud_cnt <= 24'h0;
      o_ice_mode <= 1'b0;
    end else begin
      unique case (st)
        CBS_C_WAIT: begin
          if (!bus.core_rst) begin
            st <= CBS_C_USER;
          end
        end
        CBS_C_BAUD: begin
          if (i_autobaud_ok) begin
            st <= CBS_C_ISP;
          end else if (timeout) begin
            st <= CBS_C_USER;
            o_ice_mode <= i_ice_flag;
          end else begin
            baud_cnt <= baud_cnt + 24'h1;
          end
        end
        CBS_C_ISP: st <= CBS_C_ISP;
        CBS_C_USER: st <= CBS_C_USER;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      timeout_sw <= 1'b0;
      pc <= 16'h0000;
    end else begin
      timeout_sw <= timeout & ~i_autobaud_ok & ~i_ice_flag;
      pc <= bus.pc_load_en ? bus.pc_load : i_fetch_addr;
    end
  end

  // Both bits never cleared in one write; bank bit not cleared from low code in CBS_C_USER
  wire user_cfg_ok = !(i_cfg_wdata[CBS_BANK_SELECT_BIT_POS] == 1'b0 && bus.cfg_rdata[CBS_BANK_SELECT_BIT_POS] && pc <= CBS_BOOT_TOP
                     && st == CBS_C_USER) && !(bus.cfg_rdata == 2'h3 && i_cfg_wdata == 2'h0);

  assign bus.cfg_we = timeout_sw | (i_cfg_we & user_cfg_ok);
  assign bus.cfg_wdata = timeout_sw ? CBS_FCF_SOFT : i_cfg_wdata;
  assign bus.ebo_we = i_ebo_we;
  assign bus.ebo_wdata = i_ebo_wdata;
  assign bus.pof_clr = i_pof_clr;
  assign bus.watchdog_control_reg_we = 1'b0;
  assign bus.watchdog_control_reg_wdata = CBS_WATCHDOG_CONTROL_REG_RST;
  assign bus.fetch_req = i_fetch_req & ~bus.core_rst;
  assign bus.fetch_addr = i_fetch_addr;
  assign o_in_boot = st == CBS_C_BAUD;
  assign o_isp_mode = st == CBS_C_ISP;
endmodule

// ### bench/cbs_properties.sv
// Concurrent checks on the signals between controller and core side.
// Assumes the bench wires it beside the interface, on i_ref_clk.
`timescale 1ns/1ps
module cbs_properties (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Interface signals
  input wire logic [1:0] cfg_wdata,
  input wire logic cfg_we,
  input wire logic [1:0] cfg_rdata,
  input wire logic pof_clr,
  input wire logic power_on_flag,
  input wire logic ebo_wdata,
  input wire logic ebo_we,
  input wire logic brownout_irq_enable,
  input wire logic [15:0] fetch_addr,
  input wire logic fetch_req,
  input wire logic fetch_boot,
  input wire logic core_rst,
  input wire logic [2:0] rst_src,
  input wire logic [15:0] pc_load,
  input wire logic bo_irq
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  chk_boot_map: assert property (fetch_req |=> fetch_boot == ($past(fetch_addr) <= 16'h1fff && cfg_rdata == 2'h0))
    else $error("fetch block select wrong");
  chk_soft_rst: assert property (cfg_we && cfg_wdata[1] && !cfg_rdata[1] |=> cfg_rdata == 2'h2 && core_rst)
    else $error("soft reset bits wrong");
  chk_bo_vector: assert property (bo_irq |-> pc_load == 16'h004b && !core_rst)
    else $error("brownout vector wrong");
  chk_rst_stretch: assert property ($rose(core_rst) |-> core_rst [*8])
    else $error("core reset too short");
  chk_ebo_clr_rst: assert property (brownout_irq_enable && bo_irq && ebo_we && !ebo_wdata |-> ##[1:3] core_rst)
    else $error("no reset on enable clear");
  chk_irq_gate: assert property (!$past(brownout_irq_enable) |-> !bo_irq)
    else $error("irq while disabled");
  chk_bo_wd_bits: assert property ($rose(core_rst) && rst_src inside {3'h3, 3'h4}
    |-> !cfg_rdata[0] && cfg_rdata[1] == $past(cfg_rdata[1]))
    else $error("bank bits after reset wrong");
  chk_pof_hold: assert property ($fell(power_on_flag) |-> $past(pof_clr))
    else $error("power-on flag lost");
  chk_no_double: assert property (cfg_we && cfg_rdata == 2'h3 |-> cfg_wdata != 2'h0)
    else $error("both bits cleared at once");
endmodule

// ### bench/tb_cbs.sv
// Self-checking bench joining controller and core through the interface.
// Assumes a 20 MHz clock and a shortened autobaud wait.
`timescale 1ns/1ps
module tb_cbs;
  logic i_ref_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_por = 1'b0, i_rst_pin = 1'b0, i_below_vbo = 1'b0, i_wdog_trip = 1'b0;
  logic i_cfg_we = 1'b0, i_ebo_we = 1'b0, i_ebo_wdata = 1'b0, i_pof_clr = 1'b0, i_fetch_req = 1'b0;
  logic [1:0] i_cfg_wdata = 2'h0;
  logic [15:0] i_fetch_addr = 16'h0000;
  logic [9:0] sec_cnt;
  logic brown, in_boot, isp_mode, ice_mode;
  logic i_ice_flag = 1'b0, i_autobaud_ok = 1'b0;
  int err_total = 0;
  int num_checks = 0;
  cbs_if bus();
  cbs_ctrl #(.SIZE_KB(64)) u_cbs_ctrl (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_por(i_por),
    .i_rst_pin(i_rst_pin), .i_below_vbo(i_below_vbo), .i_wdog_trip(i_wdog_trip), .bus(bus),
    .o_sector_count(sec_cnt), .o_brownout(brown));
  cbs_core #(.AUTOBAUD_CYC(50)) u_cbs_core (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_autobaud_ok(i_autobaud_ok), .i_ice_flag(i_ice_flag), .i_cfg_we(i_cfg_we), .i_cfg_wdata(i_cfg_wdata),
    .i_ebo_we(i_ebo_we), .i_ebo_wdata(i_ebo_wdata), .i_pof_clr(i_pof_clr), .i_fetch_req(i_fetch_req),
    .i_fetch_addr(i_fetch_addr), .o_in_boot(in_boot), .o_isp_mode(isp_mode), .o_ice_mode(ice_mode), .bus(bus));
  cbs_properties u_cbs_properties (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .cfg_wdata(bus.cfg_wdata),
    .cfg_we(bus.cfg_we), .cfg_rdata(bus.cfg_rdata), .pof_clr(bus.pof_clr), .power_on_flag(bus.power_on_flag),
    .ebo_wdata(bus.ebo_wdata), .ebo_we(bus.ebo_we), .brownout_irq_enable(bus.brownout_irq_enable), .fetch_addr(bus.fetch_addr),
    .fetch_req(bus.fetch_req), .fetch_boot(bus.fetch_boot), .core_rst(bus.core_rst),
    .rst_src(bus.rst_src), .pc_load(bus.pc_load), .bo_irq(bus.bo_irq));
  initial begin
    forever #25 i_ref_clk = ~i_ref_clk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic wait_rst(input logic lvl);
    for (int n = 0; n < 300 && bus.core_rst !== lvl; n++) tick(1);
    chk("core_rst", lvl, bus.core_rst);
  endtask
  task automatic cfg_wr(input logic [1:0] v);
    @(posedge i_ref_clk);
    i_cfg_we <= 1'b1;
    i_cfg_wdata <= v;
    @(posedge i_ref_clk);
    i_cfg_we <= 1'b0;
    tick(3);
  endtask
  task automatic ebo_wr(input logic v);
    @(posedge i_ref_clk);
    i_ebo_we <= 1'b1;
    i_ebo_wdata <= v;
    @(posedge i_ref_clk);
    i_ebo_we <= 1'b0;
  endtask
  task automatic fetch(input logic [15:0] a, input logic exp);
    @(posedge i_ref_clk);
    i_fetch_req <= 1'b1;
    i_fetch_addr <= a;
    tick(1);
    for (int n = 0; n < 8 && !(bus.fetch_valid === 1'b1 && bus.fetch_addr_q === a); n++) tick(1);
    chk("fetch_boot", exp, bus.fetch_boot);
    @(posedge i_ref_clk);
    i_fetch_req <= 1'b0;
  endtask
  task automatic drive_below(input logic v);
    @(posedge i_ref_clk);
    i_below_vbo <= v;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk("pof", 1, bus.power_on_flag);
    chk("cfg", 0, bus.cfg_rdata);
    chk("sectors", 512, sec_cnt);
    wait_rst(0);
    @(posedge i_ref_clk);
    i_pof_clr <= 1'b1;
    @(posedge i_ref_clk);
    i_pof_clr <= 1'b0;
    tick(3);
    chk("pof", 0, bus.power_on_flag);
  endtask
  task automatic t_map;
    fetch(16'h0000, 1);
    fetch(16'h1fff, 1);
    fetch(16'h2000, 0);
    cfg_wr(2'h1);
    chk("cfg", 1, bus.cfg_rdata);
    fetch(16'h0000, 0);
    cfg_wr(2'h3);
    chk("core_rst", 1, bus.core_rst);
    chk("cfg", 2, bus.cfg_rdata);
    chk("rst_src", 2, bus.rst_src);
    wait_rst(0);
    fetch(16'h1fff, 0);
  endtask
  task automatic t_brown;
    drive_below(1'b1);
    tick(2);
    chk("brownout", 0, brown);
    for (int n = 0; n < 8 && brown !== 1'b1; n++) tick(1);
    chk("brownout", 1, brown);
    tick(2);
    chk("core_rst", 1, bus.core_rst);
    chk("cfg", 2, bus.cfg_rdata);
    chk("rst_src", 3, bus.rst_src);
    drive_below(1'b0);
    wait_rst(0);
  endtask
  task automatic t_irq;
    ebo_wr(1'b1);
    tick(3);
    drive_below(1'b1);
    for (int n = 0; n < 10 && bus.bo_irq !== 1'b1; n++) tick(1);
    chk("bo_irq", 1, bus.bo_irq);
    chk("pc_load", 16'h004b, bus.pc_load);
    chk("core_rst", 0, bus.core_rst);
    ebo_wr(1'b0);
    wait_rst(1);
    drive_below(1'b0);
    wait_rst(0);
  endtask
  task automatic t_wdog;
    cfg_wr(2'h3);
    chk("cfg", 3, bus.cfg_rdata);
    cfg_wr(2'h0);
    chk("cfg", 3, bus.cfg_rdata);
    @(posedge i_ref_clk);
    i_wdog_trip <= 1'b1;
    @(posedge i_ref_clk);
    i_wdog_trip <= 1'b0;
    wait_rst(1);
    chk("cfg", 2, bus.cfg_rdata);
    chk("rst_src", 4, bus.rst_src);
    wait_rst(0);
  endtask
  task automatic t_boot;
    for (int k = 0; k < 4; k++) begin
      @(posedge i_ref_clk);
      {i_por, i_rst_pin} <= (k == 0) ? 2'h2 : 2'h1;
      i_ice_flag <= (k == 2);
      i_autobaud_ok <= (k == 3);
      tick(30);
      @(posedge i_ref_clk);
      {i_por, i_rst_pin} <= 2'h0;
      wait_rst(0);
      tick(1);
      chk("cfg", 0, bus.cfg_rdata);
      chk("in_boot", k != 3, in_boot);
      if (k == 0) chk("pof", 1, bus.power_on_flag);
      for (int n = 0; n < 300 && bus.rst_src !== 3'h2; n++) tick(1);
      chk("rst_src", (k < 2) ? 2 : 1, bus.rst_src);
      wait_rst(0);
      chk("cfg", (k < 2) ? 2 : 0, bus.cfg_rdata);
      chk("ice_mode", k == 2, ice_mode);
      chk("isp_mode", k == 3, isp_mode);
    end
  endtask
  task automatic print_verdict;
    if (err_total == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    tick(1);
    t_reset;
    t_map;
    t_brown;
    t_irq;
    t_wdog;
    t_boot;
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    err_total++;
    print_verdict;
  end
endmodule
